// *** logic/io_line_params.svh ***
// Constants for the I/O line configuration and PWM block.
`ifndef IO_LINE_PARAMS_SVH
`define IO_LINE_PARAMS_SVH

// Pin function codes.
`define FN_DISABLED 3'h0
`define FN_SPECIAL 3'h1
`define FN_PWM 3'h2
`define FN_INPUT 3'h3
`define FN_OUT_LOW 3'h4
`define FN_OUT_HIGH 3'h5

// Index of each configurable pin inside the function array.
`define IDX_ASSOC 3'h0
`define IDX_SLEEP_REQ 3'h1
`define IDX_SLEEP_IND 3'h2
`define IDX_RSSI_PWM 3'h3
`define IDX_PWM_ONE 3'h4
`define IDX_MISO 3'h5
`define NUM_MANAGED 6
`define NUM_LINES 20

// I/O line number of each configurable pin.
`define LINE_ASSOC 5'h05
`define LINE_SLEEP_REQ 5'h08
`define LINE_SLEEP_IND 5'h09
`define LINE_RSSI_PWM 5'h0A
`define LINE_PWM_ONE 5'h0B
`define LINE_MISO 5'h0C

// Reset values.
`define FN_RST_ASSOC 3'h1
`define FN_RST_SLEEP_REQ 3'h1
`define FN_RST_SLEEP_IND 3'h1
`define FN_RST_RSSI_PWM 3'h1
`define FN_RST_PWM_ONE 3'h0
`define FN_RST_MISO 3'h0
`define MASK_RESET 20'h0FFFF
`define MASK_TH_WIDTH 20'h0FFFF
`define DUTY_RESET 10'h000
`define DUTY_MAX 10'h3FF
`define RSSI_TIMER_RESET 8'h28
`define RSSI_ALWAYS_ON 8'hFF
`define BLINK_RESET 8'h00

// Timing, each in its own unit.
`define CLK_PERIOD_NS 5
`define PWM_PERIOD_NS 64000
`define PWM_STEPS 1023
`define RSSI_UNIT_MS 100
`define BLINK_DEFAULT_MS 250
`define BLINK_UNIT_MS 10
`define NS_PER_MS 1000000

`endif

// *** logic/io_line_pkg.sv ***
// Types shared by the I/O line configuration and PWM block.
`default_nettype none
package io_line_pkg;
    typedef enum logic [3:0] {
        SEL_ASSOC_FN,
        SEL_SLEEP_REQ_FN,
        SEL_SLEEP_IND_FN,
        SEL_RSSI_PWM_FN,
        SEL_PWM_ONE_FN,
        SEL_MISO_FN,
        SEL_PULL_EN,
        SEL_PULL_DIR,
        SEL_OUT_LEVEL,
        SEL_DUTY_ZERO,
        SEL_DUTY_ONE,
        SEL_RSSI_TIMER,
        SEL_BLINK_TIME
    } param_sel_t;

    typedef struct packed {
        logic wr;
        logic apply;
        param_sel_t sel;
        logic [19:0] data;
    } cmd_t;

    typedef struct packed {
        logic joined;
        logic asleep;
    } node_status_t;

    typedef struct packed {
        logic valid;
        logic src_match;
        logic [9:0] value;
    } rx_sample_t;

    typedef struct packed {
        logic valid;
        logic [9:0] level;
    } rssi_t;

    typedef struct packed {
        logic [19:0] out;
        logic [19:0] oe_n;
        logic [19:0] pull_en;
        logic [19:0] pull_up;
    } pad_ctl_t;
endpackage
`default_nettype wire

// *** logic/pwm_channel.sv ***
// One 10-bit PWM channel with a fixed period split into equal steps.
`timescale 1ns/10ps
`default_nettype none
`include "io_line_params.svh"
module pwm_channel (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Duty and waveform.
    input wire logic [9:0] duty,
    output var logic pwm_r
);
    // Step length rounds down so that one period never exceeds its nominal length.
    localparam int STEP_CYC = `PWM_PERIOD_NS / (`PWM_STEPS * `CLK_PERIOD_NS);

    logic [3:0] step_r, step_nxt;
    logic [9:0] slot_r, slot_nxt;
    logic pwm_nxt;

    // Slot counter runs 0 to 1022, so a duty of all ones is high throughout.
    always_comb
    begin
        step_nxt = step_r + 4'h1;
        slot_nxt = slot_r;
        if (step_r == 4'(STEP_CYC - 1))
        begin
            step_nxt = 4'h0;
            slot_nxt = (slot_r == 10'(`PWM_STEPS - 1)) ? 10'h000 : slot_r + 10'h001;
        end
        pwm_nxt = (slot_r < duty);
    end

    // State registers.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            step_r <= 4'h0;
            slot_r <= 10'h000;
            pwm_r <= 1'b0;
        end
        else
        begin
            step_r <= step_nxt;
            slot_r <= slot_nxt;
            pwm_r <= pwm_nxt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_duty_full;
        duty == `DUTY_MAX |=> pwm_r;
    endproperty
    a_duty_full: assert property (p_duty_full) else $error("Full duty did not give high output.");

    property p_duty_zero;
        duty == `DUTY_RESET |=> !pwm_r;
    endproperty
    a_duty_zero: assert property (p_duty_zero) else $error("Zero duty did not give low output.");
endmodule
`default_nettype wire

// *** logic/io_line_config_pwm.sv ***
// Pin function selection, pull control, output levels and PWM for the I/O lines.
`timescale 1ns/10ps
`default_nettype none
`include "io_line_params.svh"
module io_line_config_pwm #(
    parameter int RSSI_TICK_CYC = `RSSI_UNIT_MS * (`NS_PER_MS / `CLK_PERIOD_NS),
    parameter int BLINK_DEFAULT_CYC = `BLINK_DEFAULT_MS * (`NS_PER_MS / `CLK_PERIOD_NS),
    parameter int BLINK_UNIT_CYC = `BLINK_UNIT_MS * (`NS_PER_MS / `CLK_PERIOD_NS)
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Command-mode parameter access.
    input wire io_line_pkg::cmd_t cmd,
    input wire io_line_pkg::param_sel_t rd_sel,
    output var logic [19:0] rd_data_r,
    output var logic cmd_err_r,
    // Node state from the radio and sleep logic.
    input wire io_line_pkg::node_status_t status,
    input wire io_line_pkg::rssi_t rssi,
    input wire io_line_pkg::rx_sample_t rx,
    input wire logic spi_miso_out,
    // Pins.
    input wire logic [19:0] pad_in,
    input wire logic variant_th_pin,
    output var io_line_pkg::pad_ctl_t pad_ctl_r,
    output var logic [19:0] pad_in_r,
    output var logic sleep_request_r
);
    import io_line_pkg::*;

    // Accepted function values per configurable pin.
    function automatic logic fn_ok(input logic [2:0] k, input logic [2:0] v, input logic th);
        case (v)
            `FN_DISABLED, `FN_INPUT, `FN_OUT_LOW, `FN_OUT_HIGH: fn_ok = 1'b1;
            `FN_SPECIAL: fn_ok = (k == `IDX_PWM_ONE) ? 1'b0 : ((k == `IDX_MISO) ? th : 1'b1);
            `FN_PWM: fn_ok = (k == `IDX_RSSI_PWM) || (k == `IDX_PWM_ONE);
            default: fn_ok = 1'b0;
        endcase
    endfunction

    // Line number of each configurable pin.
    function automatic logic [4:0] managed_line(input logic [2:0] k);
        case (k)
            `IDX_ASSOC: managed_line = `LINE_ASSOC;
            `IDX_SLEEP_REQ: managed_line = `LINE_SLEEP_REQ;
            `IDX_SLEEP_IND: managed_line = `LINE_SLEEP_IND;
            `IDX_RSSI_PWM: managed_line = `LINE_RSSI_PWM;
            `IDX_PWM_ONE: managed_line = `LINE_PWM_ONE;
            default: managed_line = `LINE_MISO;
        endcase
    endfunction

    // Line reached by each pull mask bit.
    function automatic logic [4:0] mask_line(input logic [4:0] b);
        case (b)
            5'h00: mask_line = 5'h04;
            5'h01: mask_line = 5'h03;
            5'h02: mask_line = 5'h02;
            5'h03: mask_line = 5'h01;
            5'h04: mask_line = 5'h00;
            5'h05: mask_line = 5'h06;
            5'h06: mask_line = 5'h08;
            5'h07: mask_line = 5'h0E;
            5'h08: mask_line = 5'h05;
            5'h09: mask_line = 5'h09;
            5'h0A: mask_line = 5'h0C;
            5'h0B: mask_line = 5'h0A;
            5'h0C: mask_line = 5'h0B;
            5'h0D: mask_line = 5'h07;
            5'h0E: mask_line = 5'h0D;
            default: mask_line = b;
        endcase
    endfunction

    logic [19:0] pad_s1_r;
    logic th_s1_r, th_s2_r, th_r, th_arm_r, th_done_r;
    logic [5:0][2:0] fn_r, fn_nxt;
    logic [5:0] level_r, level_nxt;
    logic [19:0] pen_r, pen_nxt, pdir_r, pdir_nxt;
    logic [9:0] duty0_pend_r, duty0_pend_nxt, duty1_pend_r, duty1_pend_nxt;
    logic [9:0] duty0_r, duty0_nxt, duty1_r, duty1_nxt;
    logic [7:0] rssi_set_r, rssi_set_nxt, blink_set_r, blink_set_nxt;
    logic err_nxt;
    logic [19:0] rd_nxt, wmask;
    logic [2:0] widx;
    logic lp_hit0, lp_hit1;

    // Pins and the variant strap come from outside; th_r is loaded once, at the second edge after reset, from th_s2_r still at its reset value.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pad_s1_r <= 20'h00000;
            pad_in_r <= 20'h00000;
            th_s1_r <= 1'b0;
            th_s2_r <= 1'b0;
            th_r <= 1'b0;
            th_arm_r <= 1'b0;
            th_done_r <= 1'b0;
        end
        else
        begin
            pad_s1_r <= pad_in;
            pad_in_r <= pad_s1_r;
            th_s1_r <= variant_th_pin;
            th_s2_r <= th_s1_r;
            th_arm_r <= 1'b1;
            th_done_r <= th_arm_r;
            if (th_arm_r && !th_done_r) // A first-edge capture would take the reset value.
                th_r <= th_s2_r;
        end
    end

    assign lp_hit0 = rx.valid && rx.src_match && (fn_r[`IDX_RSSI_PWM] == `FN_PWM);
    assign lp_hit1 = rx.valid && rx.src_match && (fn_r[`IDX_PWM_ONE] == `FN_PWM);
    assign widx = cmd.sel[2:0];
    assign wmask = th_r ? `MASK_TH_WIDTH : 20'hFFFFF;

    // Settings: command writes, apply and line passing. Apply wins over a sample that lands
    // in the same cycle, since software asked for that value last.
    always_comb
    begin
        fn_nxt = fn_r;
        level_nxt = level_r;
        pen_nxt = pen_r;
        pdir_nxt = pdir_r;
        duty0_pend_nxt = duty0_pend_r;
        duty1_pend_nxt = duty1_pend_r;
        duty0_nxt = duty0_r;
        duty1_nxt = duty1_r;
        rssi_set_nxt = rssi_set_r;
        blink_set_nxt = blink_set_r;
        err_nxt = 1'b0;
        if (lp_hit0)
            duty0_nxt = rx.value;
        if (lp_hit1)
            duty1_nxt = rx.value;
        if (cmd.apply)
        begin
            duty0_nxt = duty0_pend_r;
            duty1_nxt = duty1_pend_r;
        end
        if (cmd.wr)
        begin
            case (cmd.sel)
                SEL_ASSOC_FN, SEL_SLEEP_REQ_FN, SEL_SLEEP_IND_FN, SEL_RSSI_PWM_FN,
                SEL_PWM_ONE_FN, SEL_MISO_FN:
                begin
                    if (fn_ok(widx, cmd.data[2:0], th_r) && cmd.data[19:3] == 17'h00000)
                    begin
                        fn_nxt[widx] = cmd.data[2:0];
                        if (cmd.data[2:0] == `FN_OUT_LOW || cmd.data[2:0] == `FN_OUT_HIGH)
                            level_nxt[widx] = (cmd.data[2:0] == `FN_OUT_HIGH);
                    end
                    else
                        err_nxt = 1'b1;
                end
                SEL_PULL_EN: pen_nxt = cmd.data & wmask;
                SEL_PULL_DIR: pdir_nxt = cmd.data & wmask;
                SEL_OUT_LEVEL:
                begin
                    for (int k = 0; k < `NUM_MANAGED; k++)
                        if (fn_r[k] == `FN_OUT_LOW || fn_r[k] == `FN_OUT_HIGH)
                            level_nxt[k] = cmd.data[k];
                end
                SEL_DUTY_ZERO: duty0_pend_nxt = cmd.data[9:0];
                SEL_DUTY_ONE: duty1_pend_nxt = cmd.data[9:0];
                SEL_RSSI_TIMER: rssi_set_nxt = cmd.data[7:0];
                SEL_BLINK_TIME: blink_set_nxt = cmd.data[7:0];
                default: err_nxt = 1'b1;
            endcase
        end
    end

    // Settings registers.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fn_r <= {`FN_RST_MISO, `FN_RST_PWM_ONE, `FN_RST_RSSI_PWM, `FN_RST_SLEEP_IND,
                     `FN_RST_SLEEP_REQ, `FN_RST_ASSOC};
            level_r <= 6'h00;
            pen_r <= `MASK_RESET;
            pdir_r <= `MASK_RESET;
            duty0_pend_r <= `DUTY_RESET;
            duty1_pend_r <= `DUTY_RESET;
            duty0_r <= `DUTY_RESET;
            duty1_r <= `DUTY_RESET;
            rssi_set_r <= `RSSI_TIMER_RESET;
            blink_set_r <= `BLINK_RESET;
            cmd_err_r <= 1'b0;
        end
        else
        begin
            fn_r <= fn_nxt;
            level_r <= level_nxt;
            pen_r <= pen_nxt;
            pdir_r <= pdir_nxt;
            duty0_pend_r <= duty0_pend_nxt;
            duty1_pend_r <= duty1_pend_nxt;
            duty0_r <= duty0_nxt;
            duty1_r <= duty1_nxt;
            rssi_set_r <= rssi_set_nxt;
            blink_set_r <= blink_set_nxt;
            cmd_err_r <= err_nxt;
        end
    end

    logic [9:0] rssi_duty_r, rssi_duty_nxt;
    logic rssi_on_r, rssi_on_nxt, blink_r, blink_nxt;
    logic [7:0] rssi_left_r, rssi_left_nxt;
    logic [31:0] tick_r, tick_nxt, blink_cnt_r, blink_cnt_nxt, blink_half;

    // RSSI hold timer and associate blink timer.
    always_comb
    begin
        rssi_duty_nxt = rssi_duty_r;
        rssi_on_nxt = rssi_on_r;
        rssi_left_nxt = rssi_left_r;
        tick_nxt = tick_r;
        if (rssi.valid)
        begin
            rssi_duty_nxt = rssi.level;
            rssi_left_nxt = rssi_set_r;
            rssi_on_nxt = (rssi_set_r != 8'h00);
            tick_nxt = 32'h00000000;
        end
        else if (rssi_on_r && rssi_set_r != `RSSI_ALWAYS_ON)
        begin
            tick_nxt = tick_r + 32'h00000001;
            if (tick_r == 32'(RSSI_TICK_CYC - 1))
            begin
                tick_nxt = 32'h00000000;
                rssi_left_nxt = rssi_left_r - 8'h01;
                if (rssi_left_r <= 8'h01)
                    rssi_on_nxt = 1'b0;
            end
        end
        blink_half = (blink_set_r == 8'h00) ? 32'(BLINK_DEFAULT_CYC)
            : 32'(BLINK_UNIT_CYC) * {24'h000000, blink_set_r};
        blink_cnt_nxt = blink_cnt_r + 32'h00000001;
        blink_nxt = blink_r;
        if (!status.joined)
        begin
            blink_cnt_nxt = 32'h00000000;
            blink_nxt = 1'b0;
        end
        else if (blink_cnt_r >= blink_half - 32'h00000001)
        begin
            blink_cnt_nxt = 32'h00000000;
            blink_nxt = !blink_r;
        end
    end

    // Timer registers.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rssi_duty_r <= `DUTY_RESET;
            rssi_on_r <= 1'b0;
            rssi_left_r <= 8'h00;
            tick_r <= 32'h00000000;
            blink_cnt_r <= 32'h00000000;
            blink_r <= 1'b0;
        end
        else
        begin
            rssi_duty_r <= rssi_duty_nxt;
            rssi_on_r <= rssi_on_nxt;
            rssi_left_r <= rssi_left_nxt;
            tick_r <= tick_nxt;
            blink_cnt_r <= blink_cnt_nxt;
            blink_r <= blink_nxt;
        end
    end

    logic pwm_rssi, pwm_zero, pwm_one;

    pwm_channel u_pwm_rssi (.sys_clk(sys_clk), .rst_n(rst_n), .duty(rssi_duty_r), .pwm_r(pwm_rssi));
    pwm_channel u_pwm_zero (.sys_clk(sys_clk), .rst_n(rst_n), .duty(duty0_r), .pwm_r(pwm_zero));
    pwm_channel u_pwm_one (.sys_clk(sys_clk), .rst_n(rst_n), .duty(duty1_r), .pwm_r(pwm_one));

    pad_ctl_t pad_nxt;
    logic [19:0][2:0] line_fn;
    logic [4:0] ln;

    // Pad drive and pulls. Unconfigurable lines count as disabled, so their pulls follow the masks.
    always_comb
    begin
        pad_nxt.out = 20'h00000;
        pad_nxt.oe_n = 20'hFFFFF;
        pad_nxt.pull_en = 20'h00000;
        pad_nxt.pull_up = 20'h00000;
        line_fn = '0;
        ln = 5'h00;
        for (int k = 0; k < `NUM_MANAGED; k++)
        begin
            ln = managed_line(3'(k));
            line_fn[ln] = fn_r[k];
            case (fn_r[k])
                `FN_OUT_LOW, `FN_OUT_HIGH:
                begin
                    pad_nxt.oe_n[ln] = 1'b0;
                    pad_nxt.out[ln] = level_r[k];
                end
                `FN_PWM:
                begin
                    pad_nxt.oe_n[ln] = 1'b0;
                    pad_nxt.out[ln] = (3'(k) == `IDX_PWM_ONE) ? pwm_one : pwm_zero;
                end
                `FN_SPECIAL:
                begin
                    pad_nxt.oe_n[ln] = (3'(k) == `IDX_SLEEP_REQ);
                    case (3'(k))
                        `IDX_ASSOC: pad_nxt.out[ln] = blink_r;
                        `IDX_SLEEP_IND: pad_nxt.out[ln] = !status.asleep;
                        `IDX_RSSI_PWM: pad_nxt.out[ln] = pwm_rssi && rssi_on_r;
                        `IDX_MISO: pad_nxt.out[ln] = spi_miso_out;
                        default: pad_nxt.out[ln] = 1'b0;
                    endcase
                end
                default: pad_nxt.out[ln] = 1'b0;
            endcase
        end
        for (int b = 0; b < `NUM_LINES; b++)
        begin
            ln = mask_line(5'(b));
            if (line_fn[ln] == `FN_DISABLED || line_fn[ln] == `FN_INPUT)
            begin
                pad_nxt.pull_en[ln] = pen_r[b];
                pad_nxt.pull_up[ln] = pen_r[b] && pdir_r[b];
            end
        end
    end

    // Read-back mux; the output level map is write-only and reads as zero.
    always_comb
    begin
        case (rd_sel)
            SEL_ASSOC_FN, SEL_SLEEP_REQ_FN, SEL_SLEEP_IND_FN, SEL_RSSI_PWM_FN,
            SEL_PWM_ONE_FN, SEL_MISO_FN: rd_nxt = {17'h00000, fn_r[rd_sel[2:0]]};
            SEL_PULL_EN: rd_nxt = pen_r;
            SEL_PULL_DIR: rd_nxt = pdir_r;
            SEL_DUTY_ZERO: rd_nxt = {10'h000, duty0_r};
            SEL_DUTY_ONE: rd_nxt = {10'h000, duty1_r};
            SEL_RSSI_TIMER: rd_nxt = {12'h000, rssi_set_r};
            SEL_BLINK_TIME: rd_nxt = {12'h000, blink_set_r};
            default: rd_nxt = 20'h00000;
        endcase
    end

    // Output registers.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pad_ctl_r <= {20'h00000, 20'hFFFFF, 20'h00000, 20'h00000};
            rd_data_r <= 20'h00000;
            sleep_request_r <= 1'b0;
        end
        else
        begin
            pad_ctl_r <= pad_nxt;
            rd_data_r <= rd_nxt;
            sleep_request_r <= (fn_r[`IDX_SLEEP_REQ] == `FN_SPECIAL) && pad_in_r[`LINE_SLEEP_REQ];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_reject_assoc;
        cmd.wr && cmd.sel == SEL_ASSOC_FN && cmd.data == 20'h00002
            |=> cmd_err_r && fn_r[`IDX_ASSOC] == $past(fn_r[`IDX_ASSOC]);
    endproperty
    a_reject_assoc: assert property (p_reject_assoc) else $error("Bad associate value kept.");

    property p_pwm_one_no_special;
        fn_r[`IDX_PWM_ONE] != `FN_SPECIAL;
    endproperty
    a_pwm_one_no_special: assert property (p_pwm_one_no_special) else $error("PWM one took 1.");

    property p_sleep_req_float;
        fn_r[`IDX_SLEEP_REQ] == `FN_SPECIAL && status.asleep
            |=> pad_ctl_r.oe_n[`LINE_SLEEP_REQ] && !pad_ctl_r.pull_en[`LINE_SLEEP_REQ];
    endproperty
    a_sleep_req_float: assert property (p_sleep_req_float) else $error("Sleep pin driven.");

    property p_sleep_ind;
        fn_r[`IDX_SLEEP_IND] == `FN_SPECIAL |=> pad_ctl_r.out[`LINE_SLEEP_IND] == !$past(status.asleep);
    endproperty
    a_sleep_ind: assert property (p_sleep_ind) else $error("Sleep indicator level wrong.");

    sequence s_lp_hit;
        lp_hit0 && !cmd.apply;
    endsequence
    property p_line_pass;
        s_lp_hit |=> duty0_r == $past(rx.value);
    endproperty
    a_line_pass: assert property (p_line_pass) else $error("Sample did not set duty zero.");

    sequence s_apply;
        cmd.apply ##1 !cmd.apply && !lp_hit0;
    endsequence
    property p_apply;
        s_apply |=> duty0_r == $past(duty0_pend_r, 2);
    endproperty
    a_apply: assert property (p_apply) else $error("Apply did not load duty zero.");

    property p_pull_gate;
        !(fn_r[`IDX_RSSI_PWM] == `FN_DISABLED || fn_r[`IDX_RSSI_PWM] == `FN_INPUT)
            |=> !pad_ctl_r.pull_en[`LINE_RSSI_PWM];
    endproperty
    a_pull_gate: assert property (p_pull_gate) else $error("Pull on a non-input line.");

    property p_pwm_zero_pin;
        fn_r[`IDX_RSSI_PWM] == `FN_PWM
            |=> !pad_ctl_r.oe_n[`LINE_RSSI_PWM] && pad_ctl_r.out[`LINE_RSSI_PWM] == $past(pwm_zero);
    endproperty
    a_pwm_zero_pin: assert property (p_pwm_zero_pin) else $error("Channel zero not on pin.");

    property p_rssi_hold;
        rssi_set_r == `RSSI_ALWAYS_ON && rssi_on_r && !rssi.valid |=> rssi_on_r;
    endproperty
    a_rssi_hold: assert property (p_rssi_hold) else $error("Always-on RSSI output stopped.");
endmodule
`default_nettype wire

// *** test/pad_model.sv ***
// Outside circuitry on the I/O pads: resolves each line's level.
`timescale 1ns/10ps
`default_nettype none
module pad_model (
    // Clock and pad control from the block.
    input wire logic sys_clk,
    input wire io_line_pkg::pad_ctl_t ctl,
    // Resolved line levels.
    output var logic [19:0] level
);
    import io_line_pkg::*;
    logic [19:0] float_r = 20'h00000;
    // A floating line toggles so a stale level can never pass for a real one.
    always @(posedge sys_clk) float_r <= ~float_r;
    // Driver first, then the pull resistor, else the line floats.
    always_comb
        for (int i = 0; i < 20; i++)
            level[i] = !ctl.oe_n[i] ? ctl.out[i] : (ctl.pull_en[i] ? ctl.pull_up[i] : float_r[i]);
endmodule
`default_nettype wire

// *** test/io_line_config_pwm_tb_top.sv ***
// Testbench for the I/O line configuration and PWM block.
`timescale 1ns/10ps
`default_nettype none
module io_line_config_pwm_tb_top;
    import io_line_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    cmd_t cmd = '0;
    rx_sample_t rx = '0;
    param_sel_t rd_sel = SEL_ASSOC_FN;
    logic [19:0] rd_data_r, pad_in_r, pad_in;
    logic cmd_err_r, sleep_request_r;
    pad_ctl_t pad_ctl_r;
    node_status_t status = '0;
    rssi_t rssi = '0;
    int n_fail = 0;
    int n_checks = 0;
    int n_err = 0;
    int e0;
    // Small tick counts keep the timers short in simulation.
    io_line_config_pwm #(.RSSI_TICK_CYC(20), .BLINK_DEFAULT_CYC(50), .BLINK_UNIT_CYC(2)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .cmd(cmd), .rd_sel(rd_sel), .rd_data_r(rd_data_r),
        .cmd_err_r(cmd_err_r), .status(status), .rssi(rssi), .rx(rx), .spi_miso_out(1'b0),
        .pad_in(pad_in), .variant_th_pin(1'b0), .pad_ctl_r(pad_ctl_r), .pad_in_r(pad_in_r),
        .sleep_request_r(sleep_request_r));
    pad_model ext (.sys_clk(sys_clk), .ctl(pad_ctl_r), .level(pad_in));
    always #2.5 sys_clk = ~sys_clk;
    // Counts every cycle the error flag stands, so a long pulse shows up.
    always @(posedge sys_clk) n_err <= n_err + int'(cmd_err_r === 1'b1);
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input param_sel_t s, input logic [19:0] d, input logic ap);
        @(posedge sys_clk);
        cmd <= '{wr: 1'b1, apply: ap, sel: s, data: d};
        @(posedge sys_clk);
        cmd <= '0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    task automatic rd(input param_sel_t s, input logic [19:0] exp);
        @(posedge sys_clk);
        rd_sel <= s;
        repeat (2) @(posedge sys_clk);
        #1 chk(rd_data_r, exp);
    endtask
    task automatic sample(input logic m, input logic [9:0] v);
        @(posedge sys_clk);
        rx <= '{valid: 1'b1, src_match: m, value: v};
        @(posedge sys_clk);
        rx <= '0;
        repeat (4) @(posedge sys_clk);
    endtask
    // High cycles over one whole period give duty times 12 whatever the phase.
    task automatic meas(input int cyc, input int line, input logic [19:0] exp);
        int hi;
        hi = 0;
        repeat (cyc)
        begin
            @(posedge sys_clk);
            #1 hi += int'(pad_ctl_r.out[line] === 1'b1);
        end
        chk(20'(hi), exp);
    endtask
    // One packet at the strongest level, so the RSSI waveform is high throughout.
    task automatic pulse_rssi;
        @(posedge sys_clk);
        rssi <= '{valid: 1'b1, level: 10'h3FF};
        @(posedge sys_clk);
        rssi <= '0;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Reset values, then the sleep pins while the node sleeps.
    task automatic test_reset;
        rd(SEL_PULL_EN, 20'h0FFFF);
        rd(SEL_PULL_DIR, 20'h0FFFF);
        rd(SEL_DUTY_ZERO, 20'h00000);
        rd(SEL_MISO_FN, 20'h00000);
        chk({pad_ctl_r.oe_n[8], pad_ctl_r.pull_en[8]}, 20'h2);
        chk({pad_ctl_r.oe_n[9], pad_ctl_r.out[9]}, 20'h1);
        @(posedge sys_clk);
        status.asleep <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 chk({pad_ctl_r.oe_n[8], pad_ctl_r.pull_en[8]}, 20'h2);
        chk({pad_ctl_r.oe_n[9], pad_ctl_r.out[9]}, 20'h0);
        @(posedge sys_clk);
        status.asleep <= 1'b0;
        $display("reset values done");
    endtask
    // Values outside the associate and MISO pins' accepted sets raise the error flag and change nothing.
    task automatic test_reject;
        e0 = n_err;
        wr(SEL_ASSOC_FN, 20'h00002, 1'b0);
        wr(SEL_MISO_FN, 20'h00001, 1'b0);
        chk(20'(n_err - e0), 20'h00002);
        rd(SEL_ASSOC_FN, 20'h00001);
        rd(SEL_MISO_FN, 20'h00000);
        $display("rejected values done");
    endtask
    // RSSI output holds for the timer after a packet, then stops; the top value never stops.
    task automatic test_rssi;
        pulse_rssi();
        repeat (700) @(posedge sys_clk);
        #1 chk(pad_ctl_r.out[10], 20'h1);
        repeat (200) @(posedge sys_clk);
        #1 chk(pad_ctl_r.out[10], 20'h0);
        wr(SEL_RSSI_TIMER, 20'h000FF, 1'b0);
        pulse_rssi();
        repeat (900) @(posedge sys_clk);
        #1 chk(pad_ctl_r.out[10], 20'h1);
        $display("rssi done");
    endtask
    // Pulls on a disabled line, drive and level map on an output, sleep request gating.
    task automatic test_pull;
        wr(SEL_ASSOC_FN, 20'h00000, 1'b0);
        wr(SEL_PULL_DIR, 20'h0FEFF, 1'b0);
        chk({pad_ctl_r.oe_n[5], pad_ctl_r.pull_en[5], pad_ctl_r.pull_up[5]}, 20'h6);
        chk(pad_in_r[5], 20'h0);
        wr(SEL_ASSOC_FN, 20'h00005, 1'b0);
        chk({pad_ctl_r.oe_n[5], pad_ctl_r.out[5], pad_ctl_r.pull_en[5]}, 20'h2);
        chk(pad_in_r[5], 20'h1);
        wr(SEL_OUT_LEVEL, 20'h00000, 1'b0);
        chk(pad_in_r[5], 20'h0);
        wr(SEL_SLEEP_REQ_FN, 20'h00000, 1'b0);
        chk({pad_in_r[8], sleep_request_r}, 20'h2);
        wr(SEL_SLEEP_REQ_FN, 20'h00001, 1'b0);
        $display("pull and drive done");
    endtask
    // Associate indicator while joined: half its cycles high at default and set blink times.
    task automatic test_blink;
        wr(SEL_ASSOC_FN, 20'h00001, 1'b0);
        @(posedge sys_clk);
        status.joined <= 1'b1;
        repeat (20) @(posedge sys_clk);
        meas(100, 5, 20'h00032);
        wr(SEL_BLINK_TIME, 20'h00014, 1'b0);
        repeat (100) @(posedge sys_clk);
        meas(80, 5, 20'h00028);
        @(posedge sys_clk);
        status.joined <= 1'b0;
        $display("blink done");
    endtask
    // Duty through apply and line passing on channel zero, line passing on channel one.
    task automatic test_pwm;
        wr(SEL_RSSI_PWM_FN, 20'h00002, 1'b0);
        chk(pad_ctl_r.oe_n[10], 20'h0);
        wr(SEL_DUTY_ZERO, 20'h001FF, 1'b0);
        meas(12276, 10, 20'h00000);
        wr(SEL_BLINK_TIME, 20'h00000, 1'b1);
        meas(12276, 10, 20'h017F4);
        sample(1'b0, 10'h3FF);
        meas(12276, 10, 20'h017F4);
        sample(1'b1, 10'h3FF);
        meas(12276, 10, 20'h02FF4);
        wr(SEL_PWM_ONE_FN, 20'h00002, 1'b0);
        chk(pad_ctl_r.oe_n[11], 20'h0);
        sample(1'b1, 10'h155);
        rd(SEL_DUTY_ONE, 20'h00155);
        rd(SEL_DUTY_ZERO, 20'h00155);
        $display("pwm channels done");
    endtask
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        test_reset();
        test_reject();
        test_rssi();
        test_pull();
        test_blink();
        test_pwm();
        complete_run();
    end
    // Guard against a hang.
    initial
    begin
        #400us;
        n_fail++;
        complete_run();
    end
endmodule
`default_nettype wire
